// ### hdl/flash_prot_pkg.sv
package flash_prot_pkg;

    // register byte offsets
    localparam logic [7:0]  OFF_SEC         = 8'h10;
    localparam logic [7:0]  OFF_CTRL        = 8'h1c;
    localparam logic [7:0]  OFF_STAT        = 8'h20;
    localparam logic [7:0]  OFF_PROT        = 8'h30;

    // field positions
    localparam int          SEC_BIT_POS     = 0;
    localparam int          BUF_DIS_POS     = 0;
    localparam int          READY_POS       = 0;

    // values after reset
    localparam logic        SEC_BIT_RESET   = 1'b1;
    localparam logic        BUF_DIS_RESET   = 1'b0;
    localparam logic        READY_RESET     = 1'b1;

    // unlock key and its window
    localparam logic [31:0] SEC_KEY         = 32'ha74a_9d23;
    localparam logic [3:0]  FULL_WORD_SEL   = 4'hf;
    localparam int          SEC_WINDOW_CLKS = 16;

    // protect bit layout
    localparam int          NUM_BLOCKS      = 2;
    localparam int          PROT_GROUP_BITS = 4;

    // timing, 100 MHz system clock
    localparam int          CLK_MHZ         = 100;
    localparam int          HW_RST_MIN_NS   = 500;
    localparam int          HW_RST_MIN_CLKS = (HW_RST_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int          READ_WAIT_US    = 2000;
    localparam int          READ_WAIT_CLKS  = READ_WAIT_US * CLK_MHZ;

    typedef enum logic [2:0] {
        CMD_PAGE_PROG,
        CMD_BLOCK_ERASE,
        CMD_CHIP_ERASE,
        CMD_PROT_PROG,
        CMD_PROT_ERASE
    } cmd_kind_t;

    typedef enum logic [1:0] {
        ST_READY,
        ST_BUSY,
        ST_FAILED
    } op_state_t;

endpackage : flash_prot_pkg

// ### hdl/flash_protect_security_ctrl.sv
// Overview of operation
// [RL1] protect program sets that block's bit
// [RL2] protect erase clears protect bits to zero
// [RL3] protect bits readable, one per block
// [RL4] program one bit, erase four-bit group
// [RL5] lock needs enable bit and all protected
// [RL6] flash reads still work while locked
// [RL7] lock disables jtag, wire debug, trace
// [RL8] locked: commands rejected except protect erase
// [RL9] locked protect erase becomes chip erase
// [RL10] cold reset sets enable; warm keeps it
// [RL11] key then data within 16 clocks
// [RL12] key and data are full-word writes
// [RL13] control bit0: 1 disables, flushes buffer
// [RL14] software toggles buffer bit after writes
// [RL15] status bit0 busy 0, ready 1
// [RL16] success returns ready, next command taken
// [RL17] failure holds busy until hardware reset
// [RL18] software checks ready before each command
// [RL19] reset at least 0.5us, reads 2ms later
// [RL20] enable bit 1 permits security setting
// [RL21] protected block refuses program and erase
// [RL22] data write without valid key ignored
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps

module flash_protect_security_ctrl #(
    parameter int READ_WAIT = flash_prot_pkg::READ_WAIT_CLKS,
    parameter int BLOCKS    = flash_prot_pkg::NUM_BLOCKS
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic                      cold_rst,
    input  wire logic                      cyc_i,
    input  wire logic                      stb_i,
    input  wire logic                      we_i,
    input  wire logic [7:0]                adr_i,
    input  wire logic [3:0]                sel_i,
    input  wire logic [31:0]               dat_i,
    output logic      [31:0]               dat_o,
    output logic                           ack_o,
    input  wire logic                      cmd_valid,
    input  flash_prot_pkg::cmd_kind_t      cmd_kind,
    input  wire logic [$clog2(BLOCKS)-1:0] cmd_block,
    input  wire logic                      op_done,
    input  wire logic                      op_fail,
    output logic                           op_start,
    output flash_prot_pkg::cmd_kind_t      op_kind,
    output logic      [$clog2(BLOCKS)-1:0] op_block,
    output logic                           cmd_reject,
    output logic                           auto_op_ready,
    output logic      [BLOCKS-1:0]         block_protect_flags,
    output logic                           security_lock,
    output logic                           debug_disable,
    output logic                           instr_buffer_disable,
    output logic                           instr_buf_flush,
    output logic                           flash_read_en
);

    localparam int BW = $clog2(BLOCKS);
    localparam int RW = $clog2(READ_WAIT + 1);

    // warm and cold both reset everything; the enable bit takes the cold reset only
    logic any_rst;
    assign any_rst = rst | cold_rst;

    logic        bus_req;
    logic        bus_wr;
    logic        full_word;
    logic [31:0] next_dat;
    logic        next_ack;

    assign bus_req   = cyc_i & stb_i & ~ack_o;
    // writes land on the edge where the master sees ack, never before it
    assign bus_wr    = cyc_i & stb_i & ack_o & we_i;
    assign full_word = (sel_i == flash_prot_pkg::FULL_WORD_SEL);

    // one address compare shared by every write strobe
    function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
        reg_hit = (adr == off);
    endfunction : reg_hit

    // security enable bit, cold reset only
    logic security_enable_bit;
    logic next_security_enable_bit;
    logic [4:0] sec_window;
    logic [4:0] next_sec_window;

    // bus slave: one wait state, unmapped reads return zero
    always_comb begin
        next_ack = bus_req;
        next_dat = dat_o;
        if (bus_req && !we_i) begin
            next_dat = 32'h0000_0000;
            unique case (adr_i)
                flash_prot_pkg::OFF_SEC: begin
                    next_dat[flash_prot_pkg::SEC_BIT_POS] = security_enable_bit;
                end
                flash_prot_pkg::OFF_CTRL: begin
                    next_dat[flash_prot_pkg::BUF_DIS_POS] = instr_buffer_disable;
                end
                flash_prot_pkg::OFF_STAT: begin
                    next_dat[flash_prot_pkg::READY_POS] = auto_op_ready; // [RL15]
                end
                flash_prot_pkg::OFF_PROT: begin
                    next_dat[BLOCKS-1:0] = block_protect_flags; // [RL3]
                end
                default: begin
                    next_dat = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge any_rst) begin
        if (any_rst) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= next_ack;
            dat_o <= next_dat;
        end
    end

    // key window: a full-word key write opens it for 16 clocks
    logic sec_wr;
    assign sec_wr = bus_wr && reg_hit(adr_i, flash_prot_pkg::OFF_SEC) && full_word; // [RL12]

    always_comb begin
        next_sec_window = sec_window;
        if (sec_wr && sec_window != 5'd0) begin
            next_sec_window = 5'd0;
        end else if (sec_wr && dat_i == flash_prot_pkg::SEC_KEY) begin
            next_sec_window = 5'(flash_prot_pkg::SEC_WINDOW_CLKS); // [RL11]
        end else if (sec_window != 5'd0) begin
            next_sec_window = sec_window - 5'd1;
        end
    end

    always_ff @(posedge clk_sys or posedge any_rst) begin
        if (any_rst) begin
            sec_window <= 5'd0;
        end else begin
            sec_window <= next_sec_window;
        end
    end

    // partial writes and writes outside the window leave it alone
    always_comb begin
        next_security_enable_bit = security_enable_bit;
        if (sec_wr && sec_window != 5'd0) begin
            next_security_enable_bit = dat_i[flash_prot_pkg::SEC_BIT_POS]; // [RL11] [RL22]
        end
    end

    always_ff @(posedge clk_sys or posedge cold_rst) begin
        if (cold_rst) begin
            security_enable_bit <= flash_prot_pkg::SEC_BIT_RESET; // [RL10]
        end else begin
            security_enable_bit <= next_security_enable_bit;
        end
    end

    // instruction buffer control
    logic next_buf_dis;
    logic next_flush;

    always_comb begin
        next_buf_dis = instr_buffer_disable;
        next_flush   = 1'b0;
        if (bus_wr && reg_hit(adr_i, flash_prot_pkg::OFF_CTRL) && sel_i[0]) begin
            next_buf_dis = dat_i[flash_prot_pkg::BUF_DIS_POS]; // [RL13]
            next_flush   = dat_i[flash_prot_pkg::BUF_DIS_POS]; // [RL13] [RL14]
        end
    end

    always_ff @(posedge clk_sys or posedge any_rst) begin
        if (any_rst) begin
            instr_buffer_disable <= flash_prot_pkg::BUF_DIS_RESET;
            instr_buf_flush      <= 1'b0;
        end else begin
            instr_buffer_disable <= next_buf_dis;
            instr_buf_flush      <= next_flush;
        end
    end

    // command gate, protect bits and ready/busy
    flash_prot_pkg::op_state_t state;
    flash_prot_pkg::op_state_t next_state;
    flash_prot_pkg::cmd_kind_t next_op_kind;
    logic [BLOCKS-1:0] next_prot;
    logic [BW-1:0]     next_op_block;
    logic              next_op_start;
    logic              next_reject;
    logic              wipe;
    logic              next_wipe;

    always_comb begin
        next_state    = state;
        next_prot     = block_protect_flags;
        next_op_kind  = op_kind;
        next_op_block = op_block;
        next_op_start = 1'b0;
        next_reject   = 1'b0;
        next_wipe     = wipe;
        unique case (state)
            flash_prot_pkg::ST_READY: begin
                if (cmd_valid) begin
                    next_op_kind  = cmd_kind;
                    next_op_block = cmd_block;
                    next_wipe     = 1'b0;
                    next_op_start = 1'b1;
                    if (security_lock) begin
                        if (cmd_kind == flash_prot_pkg::CMD_PROT_ERASE) begin
                            next_op_kind = flash_prot_pkg::CMD_CHIP_ERASE; // [RL9]
                            next_wipe    = 1'b1; // [RL9]
                        end else begin
                            next_op_start = 1'b0; // [RL8]
                        end
                    end else if ((cmd_kind == flash_prot_pkg::CMD_PAGE_PROG ||
                                  cmd_kind == flash_prot_pkg::CMD_BLOCK_ERASE) &&
                                 block_protect_flags[cmd_block]) begin
                        next_op_start = 1'b0; // [RL21]
                    end else if (cmd_kind == flash_prot_pkg::CMD_CHIP_ERASE &&
                                 |block_protect_flags) begin
                        next_op_start = 1'b0; // [RL21]
                    end
                    next_reject = ~next_op_start;
                    if (next_op_start) begin
                        next_state = flash_prot_pkg::ST_BUSY; // [RL15]
                    end
                end
            end
            flash_prot_pkg::ST_BUSY: begin
                // a command while busy is dropped
                next_reject = cmd_valid;
                if (op_fail) begin
                    next_state = flash_prot_pkg::ST_FAILED; // [RL17]
                end else if (op_done) begin
                    next_state = flash_prot_pkg::ST_READY; // [RL16]
                    if (wipe) begin
                        next_prot = '0; // [RL9]
                    end else if (op_kind == flash_prot_pkg::CMD_PROT_PROG) begin
                        next_prot[op_block] = 1'b1; // [RL1] [RL4]
                    end else if (op_kind == flash_prot_pkg::CMD_PROT_ERASE) begin
                        for (int i = 0; i < BLOCKS; i++) begin
                            if (i / flash_prot_pkg::PROT_GROUP_BITS ==
                                int'(op_block) / flash_prot_pkg::PROT_GROUP_BITS) begin
                                next_prot[i] = 1'b0; // [RL2] [RL4]
                            end
                        end
                    end
                end
            end
            flash_prot_pkg::ST_FAILED: begin
                // only a hardware reset leaves this state
                next_reject = cmd_valid; // [RL17]
            end
            default: begin
                next_state = flash_prot_pkg::ST_FAILED;
            end
        endcase
    end

    // protect bits are volatile here; reset clears them
    always_ff @(posedge clk_sys or posedge any_rst) begin
        if (any_rst) begin
            state               <= flash_prot_pkg::ST_READY;
            block_protect_flags <= '0;
            op_kind             <= flash_prot_pkg::CMD_PAGE_PROG;
            op_block            <= '0;
            op_start            <= 1'b0;
            cmd_reject          <= 1'b0;
            wipe                <= 1'b0;
            auto_op_ready       <= flash_prot_pkg::READY_RESET;
        end else begin
            state               <= next_state;
            block_protect_flags <= next_prot;
            op_kind             <= next_op_kind;
            op_block            <= next_op_block;
            op_start            <= next_op_start;
            cmd_reject          <= next_reject;
            wipe                <= next_wipe;
            auto_op_ready       <= (next_state == flash_prot_pkg::ST_READY); // [RL15] [RL16]
        end
    end

    // lock, debug gate, read enable after reset recovery
    logic [RW-1:0] read_wait;
    logic [RW-1:0] next_read_wait;
    logic          next_lock;
    logic          next_read_en;

    always_comb begin
        next_read_wait = read_wait;
        if (read_wait != '0) begin
            next_read_wait = read_wait - RW'(1); // [RL19]
        end
        // lock uses the enable bit as the permit for security
        next_lock    = security_enable_bit & (&block_protect_flags); // [RL5] [RL20]
        // lock does not gate reads, only busy and recovery do
        next_read_en = (next_read_wait == '0) && (next_state == flash_prot_pkg::ST_READY); // [RL6]
    end

    always_ff @(posedge clk_sys or posedge any_rst) begin
        if (any_rst) begin
            read_wait     <= RW'(READ_WAIT);
            security_lock <= 1'b0;
            debug_disable <= 1'b0;
            flash_read_en <= 1'b0;
        end else begin
            read_wait     <= next_read_wait;
            security_lock <= next_lock;
            debug_disable <= next_lock; // [RL7]
            flash_read_en <= next_read_en;
        end
    end

endmodule : flash_protect_security_ctrl

// ### verif/flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       op_start,
    input  wire logic [3:0] op_len,
    input  wire logic       fail_next,
    output logic            op_done,
    output logic            op_fail
);
    logic [3:0] count;
    logic [3:0] next_count;
    // op_len picks a prompt or slow answer; zero would never end
    always_comb begin
        next_count = count;
        if (op_start) next_count = op_len;
        else if (count != 4'h0) next_count = count - 4'h1;
    end
    // a hardware reset abandons the running operation
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) count <= 4'h0;
        else count <= next_count;
    end
    assign op_done = (count == 4'h1) && !fail_next;
    assign op_fail = (count == 4'h1) && fail_next;
endmodule : flash_array_model

// ### verif/flash_protect_security_ctrl_chk.sv
`timescale 1ns/1ps
module flash_protect_security_ctrl_chk #(
    parameter int BLOCKS = 2
) (
    input wire logic                      clk_sys,
    input wire logic                      rst,
    input wire logic                      cold_rst,
    input wire logic                      cmd_valid,
    input flash_prot_pkg::cmd_kind_t      cmd_kind,
    input wire logic [$clog2(BLOCKS)-1:0] cmd_block,
    input wire logic                      op_done,
    input wire logic                      op_fail,
    input wire logic                      op_start,
    input flash_prot_pkg::cmd_kind_t      op_kind,
    input wire logic                      cmd_reject,
    input wire logic                      auto_op_ready,
    input wire logic [BLOCKS-1:0]         block_protect_flags,
    input wire logic                      security_lock,
    input wire logic                      debug_disable,
    input wire logic                      instr_buffer_disable,
    input wire logic                      instr_buf_flush
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst || cold_rst);
    // remembers a failed run; only a reset clears it
    logic failed;
    logic next_failed;
    always_comb next_failed = failed || (!auto_op_ready && op_fail);
    always_ff @(posedge clk_sys or posedge rst or posedge cold_rst) begin
        if (rst || cold_rst) failed <= 1'b0;
        else failed <= next_failed;
    end
    property p_lock; security_lock |-> $past(&block_protect_flags); endproperty
    a_lock: assert property (p_lock) else $error("lock without all blocks protected");
    property p_dbg; debug_disable == security_lock; endproperty
    a_dbg: assert property (p_dbg) else $error("debug disable differs from lock");
    property p_flags; !$stable(block_protect_flags) |-> $past(op_done); endproperty
    a_flags: assert property (p_flags) else $error("protect bits moved without op end");
    property p_one; $countones(block_protect_flags & ~$past(block_protect_flags)) <= 1; endproperty
    a_one: assert property (p_one) else $error("more than one protect bit set");
    property p_locked;
        cmd_valid && security_lock && cmd_kind != flash_prot_pkg::CMD_PROT_ERASE |=> cmd_reject && !op_start;
    endproperty
    a_locked: assert property (p_locked) else $error("locked command not refused");
    property p_chip;
        cmd_valid && security_lock && auto_op_ready && cmd_kind == flash_prot_pkg::CMD_PROT_ERASE
        |=> op_start && op_kind == flash_prot_pkg::CMD_CHIP_ERASE;
    endproperty
    a_chip: assert property (p_chip) else $error("locked erase not run as chip erase");
    property p_busy; op_start |-> !auto_op_ready; endproperty
    a_busy: assert property (p_busy) else $error("ready while starting");
    property p_busy_cmd; cmd_valid && !auto_op_ready |=> cmd_reject && !op_start; endproperty
    a_busy_cmd: assert property (p_busy_cmd) else $error("command taken while busy");
    property p_done; !failed && !auto_op_ready && op_done && !op_fail |=> auto_op_ready; endproperty
    a_done: assert property (p_done) else $error("ready not back after success");
    property p_fail; failed |-> !auto_op_ready; endproperty
    a_fail: assert property (p_fail) else $error("ready after failure");
    property p_prot;
        cmd_valid && auto_op_ready && !security_lock && block_protect_flags[cmd_block]
        && cmd_kind inside {flash_prot_pkg::CMD_PAGE_PROG, flash_prot_pkg::CMD_BLOCK_ERASE} |=> cmd_reject;
    endproperty
    a_prot: assert property (p_prot) else $error("protected block altered");
    property p_flush; instr_buf_flush |-> instr_buffer_disable; endproperty
    a_flush: assert property (p_flush) else $error("flush without buffer disable");
    c_lock: cover property (cmd_valid && security_lock);
    c_fail: cover property (failed);
    c_flush: cover property (instr_buf_flush);
endmodule : flash_protect_security_ctrl_chk

bind flash_protect_security_ctrl flash_protect_security_ctrl_chk #(.BLOCKS(BLOCKS)) u_chk (
    .clk_sys, .rst, .cold_rst, .cmd_valid, .cmd_kind, .cmd_block, .op_done, .op_fail, .op_start,
    .op_kind, .cmd_reject, .auto_op_ready, .block_protect_flags, .security_lock, .debug_disable,
    .instr_buffer_disable, .instr_buf_flush
);

// ### verif/flash_protect_security_ctrl_tb.sv
`timescale 1ns/1ps
module flash_protect_security_ctrl_tb;
    logic        clk_sys, rst, cold_rst, cyc_i, stb_i, we_i, ack_o, cmd_valid, cmd_block, op_block;
    logic        op_done, op_fail, op_start, cmd_reject, auto_op_ready, security_lock, debug_disable;
    logic        instr_buffer_disable, instr_buf_flush, flash_read_en, fail_next;
    logic [1:0]  block_protect_flags;
    logic [3:0]  sel_i, op_len;
    logic [7:0]  adr_i;
    logic [31:0] dat_i, dat_o, rd;
    int          errors, checks;
    flash_prot_pkg::cmd_kind_t cmd_kind, op_kind;
    typedef struct { logic [7:0] adr; logic [31:0] exp; } row_t;
    row_t rows [5] = '{'{8'h10, 32'h0000_0001}, '{8'h1c, 32'h0000_0000},
        '{8'h20, 32'h0000_0001}, '{8'h30, 32'h0000_0000}, '{8'h44, 32'h0000_0000}};

    flash_protect_security_ctrl #(.READ_WAIT(20), .BLOCKS(2)) uut (
        .clk_sys, .rst, .cold_rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .cmd_valid, .cmd_kind, .cmd_block, .op_done, .op_fail, .op_start, .op_kind, .op_block,
        .cmd_reject, .auto_op_ready, .block_protect_flags, .security_lock, .debug_disable,
        .instr_buffer_disable, .instr_buf_flush, .flash_read_en
    );
    flash_array_model partner (.clk_sys, .rst(rst | cold_rst), .op_start, .op_len, .fail_next, .op_done, .op_fail);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic close_out;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk

    // one classic cycle; data taken only at the ack edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
        @(posedge clk_sys);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= adr;
        sel_i <= sel;
        dat_i <= dat;
        for (int n = 0; n < 50 && ack_o !== 1'b1; n++) @(posedge clk_sys);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ack_o !== 1'b1) chk(32'h0000_0000, 32'h0000_0001, "no ack");
    endtask : wb

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 4'hf, 32'h0000_0000);
        chk(rd, exp, "register read");
    endtask : rdchk

    task automatic cmd(input flash_prot_pkg::cmd_kind_t k, input logic b, input logic go);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_block <= b;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        @(posedge clk_sys);
        chk({op_start, cmd_reject}, {go, !go}, "command answer");
    endtask : cmd

    // bounded wait for ready, then let bits and lock settle
    task automatic settle;
        for (int n = 0; n < 40 && auto_op_ready !== 1'b1; n++) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
    endtask : settle

    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        close_out();
    end

    initial begin
        errors = 0;
        checks = 0;
        {cyc_i, stb_i, we_i, cmd_valid, cmd_block, fail_next} = '0;
        {adr_i, sel_i, dat_i} = '0;
        cmd_kind = flash_prot_pkg::CMD_PAGE_PROG;
        op_len = 4'h1;
        rst = 1'b1;
        cold_rst = 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        cold_rst <= 1'b0;
        @(posedge clk_sys);
        chk(flash_read_en, 0, "read enable early");
        foreach (rows[i]) begin
            rdchk(rows[i].adr, rows[i].exp);
        end
        repeat (10) @(posedge clk_sys);
        chk(flash_read_en, 1, "read enable late");
        wb(1'b1, 8'h1c, 4'hf, 32'h0000_0001);
        @(posedge clk_sys);
        chk({instr_buf_flush, instr_buffer_disable}, 2'b11, "buffer off");
        wb(1'b1, 8'h1c, 4'hf, 32'h0000_0000);
        @(posedge clk_sys);
        chk(instr_buffer_disable, 0, "buffer on");
        wb(1'b1, 8'h20, 4'hf, 32'h0000_0000);
        rdchk(8'h20, 32'h0000_0001);
        for (int b = 0; b < 2; b++) begin
            cmd(flash_prot_pkg::CMD_PROT_PROG, b[0], 1'b1);
            chk(op_block, b[0], "op block");
            settle();
            chk(block_protect_flags, (2 << b) - 1, "one bit set");
        end
        rdchk(8'h30, 32'h0000_0003);
        chk({security_lock, debug_disable, flash_read_en}, 3'b111, "locked");
        cmd(flash_prot_pkg::CMD_PAGE_PROG, 1'b0, 1'b0);
        cmd(flash_prot_pkg::CMD_BLOCK_ERASE, 1'b1, 1'b0);
        op_len <= 4'hc;
        cmd(flash_prot_pkg::CMD_PROT_ERASE, 1'b0, 1'b1);
        chk(op_kind, flash_prot_pkg::CMD_CHIP_ERASE, "chip erase");
        settle();
        chk({block_protect_flags, security_lock}, 3'b000, "unlocked");
        wb(1'b1, 8'h10, 4'hf, 32'h0000_0000);
        rdchk(8'h10, 32'h0000_0001);
        wb(1'b1, 8'h10, 4'hf, 32'ha74a_9d23);
        repeat (14) @(posedge clk_sys);
        wb(1'b1, 8'h10, 4'hf, 32'h0000_0000);
        rdchk(8'h10, 32'h0000_0001);
        wb(1'b1, 8'h10, 4'h3, 32'ha74a_9d23);
        wb(1'b1, 8'h10, 4'hf, 32'h0000_0000);
        rdchk(8'h10, 32'h0000_0001);
        wb(1'b1, 8'h10, 4'hf, 32'ha74a_9d23);
        wb(1'b1, 8'h10, 4'hf, 32'h0000_0000);
        rdchk(8'h10, 32'h0000_0000);
        op_len <= 4'h1;
        cmd(flash_prot_pkg::CMD_PROT_PROG, 1'b0, 1'b1);
        settle();
        cmd(flash_prot_pkg::CMD_PROT_PROG, 1'b1, 1'b1);
        settle();
        chk({block_protect_flags, security_lock}, 3'b110, "no lock");
        cmd(flash_prot_pkg::CMD_PAGE_PROG, 1'b0, 1'b0);
        cmd(flash_prot_pkg::CMD_BLOCK_ERASE, 1'b1, 1'b0);
        cmd(flash_prot_pkg::CMD_CHIP_ERASE, 1'b0, 1'b0);
        op_len <= 4'hc;
        cmd(flash_prot_pkg::CMD_PROT_ERASE, 1'b0, 1'b1);
        cmd(flash_prot_pkg::CMD_PAGE_PROG, 1'b1, 1'b0);
        settle();
        chk(block_protect_flags, 2'b00, "group erased");
        cmd(flash_prot_pkg::CMD_PAGE_PROG, 1'b1, 1'b1);
        settle();
        chk(auto_op_ready, 1, "ready again");
        fail_next <= 1'b1;
        cmd(flash_prot_pkg::CMD_BLOCK_ERASE, 1'b0, 1'b1);
        repeat (20) @(posedge clk_sys);
        rdchk(8'h20, 32'h0000_0000);
        cmd(flash_prot_pkg::CMD_PAGE_PROG, 1'b0, 1'b0);
        rst <= 1'b1;
        fail_next <= 1'b0;
        // half a microsecond at this clock
        repeat (50) @(posedge clk_sys);
        rst <= 1'b0;
        rdchk(8'h20, 32'h0000_0001);
        rdchk(8'h10, 32'h0000_0000);
        cold_rst <= 1'b1;
        repeat (50) @(posedge clk_sys);
        cold_rst <= 1'b0;
        rdchk(8'h10, 32'h0000_0001);
        close_out();
    end
endmodule : flash_protect_security_ctrl_tb
